// ==== inc/flow_port_map.svh ====
// Constants of the flow sensor command port: bus address, command codes,
// status encodings, checksum setup and timing figures.
// Assumes a 40 MHz system clock; counts derive from times below.
`ifndef FLOW_PORT_MAP_SVH
`define FLOW_PORT_MAP_SVH

`define TGT_ADDR      7'h2A
`define CMD_START_O2  16'h3603
`define CMD_START_AIR 16'h3608
`define CMD_START_MIX 16'h3632
`define CMD_CONC_UPD  16'hE17D
`define CMD_PTR_RST   16'hE000

`define GAS_O2        4'h0
`define GAS_AIR       4'h1
`define GAS_MIX       4'h6
`define CONC_PURE     10'h3FF
`define CONC_MAX      16'h03E8

`define CRC_POLY      8'h31
`define CRC_INIT      8'hFF

`define RD_BYTES      4'h9
`define WR_BYTES_MAX  3'h5
`define AVG_N_MAX     8'h80
`define EXP_NUM       20'sh00005
`define EXP_SHIFT     8

`define CLK_MHZ       40
`define T_SAMPLE_NS   500000
`define T_FIRST_US    12000
`define T_EXP_NS      64000000
`define SAMPLE_CYC    (`T_SAMPLE_NS * `CLK_MHZ / 1000)
`define FIRST_CYC     (`T_FIRST_US * `CLK_MHZ)
`define AVG_LIMIT     (`T_EXP_NS / `T_SAMPLE_NS)

`endif

// ==== inc/flow_port_pkg.sv ====
// Types used by the flow sensor command port for samples, results and target state.
// Assumes nothing beyond the constants header.
package flow_port_pkg;

  typedef struct packed {
    logic signed [15:0] flow;
    logic signed [15:0] temp;
  } sample_t;

  typedef struct packed {
    logic [15:0] flow;
    logic [15:0] temp;
    logic [15:0] status;
  } result_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } tgt_state_t;

endpackage

// ==== verilog/sample_fifo.sv ====
// Synchronous FIFO for raw samples between the front end and averaging.
// Assumes one clock; in_ready comes from a register.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sample_fifo: DEPTH must be a power of two, at least 2");
  end

  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out  = mem_ff[rd_ptr_ff];

  // Occupancy: full and empty follow the count exactly
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) nxt_cnt = cnt_ff + 1'b1;
    else if (pop && !push) nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cnt_ff       <= '0;
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      in_ready_out <= 1'b0;
    end else begin
      cnt_ff       <= nxt_cnt;
      in_ready_out <= (nxt_cnt != (AW+1)'(DEPTH));  // Built from the next count, so no lag
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge mclk_in) begin
    if (push) mem_ff[wr_ptr_ff] <= in_data_in;
  end
endmodule

// ==== verilog/crc8_word.sv ====
// Checksum over one 16-bit word, high byte first, MSB first.
// Purely combinational; used for both transmit and argument checks.
`timescale 1ns/10ps
`include "flow_port_map.svh"
module crc8_word (
  input  wire logic [15:0] word_in,
  output logic [7:0]       crc_out
);
  // Bit-serial polynomial division, unrolled by the loop
  always_comb begin
    crc_out = `CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc_out[7] ^ word_in[i]) crc_out = {crc_out[6:0], 1'b0} ^ `CRC_POLY;
      else crc_out = {crc_out[6:0], 1'b0};
    end
  end
endmodule

// ==== verilog/flow_cmd_port.sv ====
// Serial-bus target and command interpreter of a gas flow sensor.
// Assumes SCL/SDA arrive asynchronously from an external open-drain bus,
// and raw samples arrive on mclk_in through a valid/ready stream.
//
// Notes on behaviour
// - Answer as target at 7-bit address 0x2A, direction bit follows.
// - Command words are sixteen bits, high byte first.
// - Argumented command: command, 16-bit argument, then its checksum.
// - Reads return 16-bit words, each followed by its checksum byte.
// - Controller NACK then STOP ends a read; release data, go idle.
// - Start code picks table: 3603 oxygen, 3608 air, 3632 mixture.
// - Only the mixture start carries an argument, the oxygen per mille.
// - Once started, keep measuring and refreshing results without commands.
// - Flow, temperature and status all readable in one read transfer.
// - First result readable 12 ms after start is accepted.
// - Read header with no data available is not acknowledged.
// - Flow low byte, flow checksum, then temperature high byte follow.
// - Flow and temperature are raw signed sixteen-bit values.
// - A status word accompanies every flow and temperature result.
// - Status 15:12 encode running start command, 3603 gives zero.
// - Status bit 10 is 0 for average-until-read, 1 for fixed count.
// - Status 9:0 are 0x3FF for pure gas, else oxygen per mille.
// - Take a new flow sample about every half millisecond.
// - Until-read past 64 ms switches to exponential smoothing, factor 0.02.
// - Concentration update accepted during measurement without stopping; an argument above 1000 stops the measurement instead.
`timescale 1ns/10ps
`include "flow_port_map.svh"
module flow_cmd_port #(
  parameter int SAMPLE_CYC = `SAMPLE_CYC,
  parameter int FIRST_CYC  = `FIRST_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        sample_valid_in,
  input  wire logic [31:0] sample_data_in,
  output logic             sample_ready_out,
  input  wire logic [7:0]  avg_n_in,
  output logic             meas_active_out,
  output logic             data_ready_out,
  output logic [3:0]       gas_sel_out,
  output logic             cmd_reject_out
);
  localparam int TW = $clog2(FIRST_CYC + 1);

  // The tick counter shares the warm-up width, so the sample period may not exceed it
  if (SAMPLE_CYC < 1 || SAMPLE_CYC > FIRST_CYC
      || FIRST_CYC < 1 || FIRST_CYC >= (1 << 24)) begin : g_chk
    $error("flow_cmd_port: timing counts out of range");
  end

  // Bus synchronisers and edge history
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Target state
  flow_port_pkg::tgt_state_t st_ff;
  logic [7:0]  sr_ff;
  logic [3:0]  bit_ff;
  logic        rd_dir_ff;
  logic        nack_ff;
  logic        wr_seen_ff;
  logic [2:0]  rx_cnt_ff;
  logic [7:0]  rx_ff [5];
  logic [3:0]  tx_idx_ff;
  logic [7:0]  tx_byte;
  logic [15:0] tx_word;
  logic [7:0]  tx_crc;

  // Measurement state
  flow_port_pkg::result_t res_ff;
  flow_port_pkg::result_t shadow_ff;
  flow_port_pkg::sample_t smp;
  logic              smp_valid;
  logic              smp_take;
  logic              meas_ff;
  logic              warm_ff;
  logic [TW-1:0]     warm_cnt_ff;
  logic [TW-1:0]     tick_cnt_ff;
  logic              tick;
  logic [3:0]        gas_ff;
  logic [9:0]        conc_ff;
  logic signed [23:0] acc_ff;
  logic [8:0]        cnt_ff;
  logic              exp_ff;
  logic signed [15:0] ema_ff;
  logic              read_take;
  logic              fixed_mode;
  logic [8:0]        n_eff;
  logic [15:0]       res_ff_status;

  // Command decode
  logic [15:0] cmd_w;
  logic [15:0] arg_w;
  logic [7:0]  arg_crc;
  logic        arg_ok;
  logic        exec;

  // Raw samples pass a FIFO so the front end can run ahead of the tick
  sample_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (sample_valid_in),
    .in_data_in    (sample_data_in),
    .in_ready_out  (sample_ready_out),
    .out_valid_out (smp_valid),
    .out_data_out  (smp),
    .out_ready_in  (smp_take)
  );

  crc8_word u_tx_crc (
    .word_in (tx_word),
    .crc_out (tx_crc)
  );

  crc8_word u_rx_crc (
    .word_in (arg_w),
    .crc_out (arg_crc)
  );

  // Two stages before anything looks at the bus, then one of history
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
    end
  end

  assign scl_rise  = scl_s2_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s2_ff & scl_d_ff;
  assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign bus_stop  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

  always_comb begin
    tx_word = shadow_ff.status;
    if (tx_idx_ff < 4'h3) tx_word = shadow_ff.flow;
    else if (tx_idx_ff < 4'h6) tx_word = shadow_ff.temp;
  end

  // word high, word low, checksum, then next word
  always_comb begin
    case (tx_idx_ff)
      4'h0, 4'h3, 4'h6: tx_byte = tx_word[15:8];
      4'h1, 4'h4, 4'h7: tx_byte = tx_word[7:0];
      4'h2, 4'h5, 4'h8: tx_byte = tx_crc;
      default:          tx_byte = 8'hFF;  // Past the end the line floats high
    endcase
  end

  // Address acknowledged with the read bit: snapshot the newest result set
  assign read_take = (st_ff == flow_port_pkg::ST_ADDR) && scl_fall && (bit_ff == 4'h8)
                     && (sr_ff[7:1] == `TGT_ADDR) && sr_ff[0] && data_ready_out;

  // Bus target sequencing; data changes only while SCL is low
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_ff      <= flow_port_pkg::ST_IDLE;
      sr_ff      <= 8'h00;
      bit_ff     <= 4'h0;
      rd_dir_ff  <= 1'b0;
      nack_ff    <= 1'b0;
      wr_seen_ff <= 1'b0;
      rx_cnt_ff  <= 3'h0;
      tx_idx_ff  <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (bus_start) begin
      st_ff      <= flow_port_pkg::ST_ADDR;
      bit_ff     <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop) begin
      st_ff      <= flow_port_pkg::ST_IDLE;
      sda_oe_out <= 1'b0;
      wr_seen_ff <= 1'b0;
    end else if (scl_rise) begin
      if (st_ff == flow_port_pkg::ST_ADDR || st_ff == flow_port_pkg::ST_WR) begin
        sr_ff  <= {sr_ff[6:0], sda_s2_ff};
        bit_ff <= bit_ff + 4'h1;
      end
      if (st_ff == flow_port_pkg::ST_RACK) nack_ff <= sda_s2_ff;
    end else if (scl_fall) begin
      case (st_ff)
        flow_port_pkg::ST_ADDR: begin
          if (bit_ff == 4'h8) begin
            // no data means no acknowledge on a read header
            if (sr_ff[7:1] == `TGT_ADDR && (!sr_ff[0] || data_ready_out)) begin
              st_ff      <= flow_port_pkg::ST_AACK;
              sda_oe_out <= 1'b1;
              rd_dir_ff  <= sr_ff[0];
              tx_idx_ff  <= 4'h0;
              if (!sr_ff[0]) begin
                rx_cnt_ff  <= 3'h0;
                wr_seen_ff <= 1'b1;
              end
            end else begin
              st_ff <= flow_port_pkg::ST_IDLE;
            end
          end
        end
        flow_port_pkg::ST_AACK: begin
          bit_ff <= 4'h0;
          if (rd_dir_ff) begin
            st_ff      <= flow_port_pkg::ST_RD;
            sr_ff      <= tx_byte;
            sda_oe_out <= ~tx_byte[7];
          end else begin
            st_ff      <= flow_port_pkg::ST_WR;
            sda_oe_out <= 1'b0;
          end
        end
        flow_port_pkg::ST_WR: begin
          // bytes gather high first into the command buffer
          if (bit_ff == 4'h8) begin
            if (rx_cnt_ff < `WR_BYTES_MAX) begin
              st_ff      <= flow_port_pkg::ST_WACK;
              sda_oe_out <= 1'b1;
              rx_cnt_ff  <= rx_cnt_ff + 3'h1;
            end else begin
              st_ff <= flow_port_pkg::ST_IDLE;  // Overlong write is refused
            end
          end
        end
        flow_port_pkg::ST_WACK: begin
          st_ff      <= flow_port_pkg::ST_WR;
          bit_ff     <= 4'h0;
          sda_oe_out <= 1'b0;
        end
        flow_port_pkg::ST_RD: begin
          if (bit_ff == 4'h7) begin
            st_ff      <= flow_port_pkg::ST_RACK;
            sda_oe_out <= 1'b0;
          end else begin
            sr_ff      <= {sr_ff[6:0], 1'b1};
            sda_oe_out <= ~sr_ff[6];
            bit_ff     <= bit_ff + 4'h1;
          end
        end
        flow_port_pkg::ST_RACK: begin
          // controller NACK ends the read early
          if (nack_ff) begin
            st_ff <= flow_port_pkg::ST_IDLE;
          end else begin
            st_ff <= flow_port_pkg::ST_RD;
            bit_ff <= 4'hF;  // Marks a byte still to be loaded
            tx_idx_ff <= tx_idx_ff + 4'h1;
          end
        end
        default: st_ff <= flow_port_pkg::ST_IDLE;
      endcase
    end else if (st_ff == flow_port_pkg::ST_RD && bit_ff == 4'hF) begin
      // First bit of each later byte, one cycle after the index moved on
      sr_ff      <= tx_byte;
      sda_oe_out <= ~tx_byte[7];
      bit_ff     <= 4'h0;
    end
  end

  // Received bytes land in order; storage needs no reset
  always_ff @(posedge mclk_in) begin
    if (st_ff == flow_port_pkg::ST_WR && scl_fall && bit_ff == 4'h8
        && rx_cnt_ff < `WR_BYTES_MAX) begin
      rx_ff[rx_cnt_ff] <= sr_ff;
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge mclk_in) begin
    sda_out <= 1'b0;
  end

  assign cmd_w  = {rx_ff[0], rx_ff[1]};
  assign arg_w  = {rx_ff[2], rx_ff[3]};
  assign arg_ok = (rx_cnt_ff == 3'h5) && (arg_crc == rx_ff[4]);
  assign exec   = bus_stop && wr_seen_ff;

  // Command execution at STOP after a write
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meas_ff        <= 1'b0;
      gas_ff         <= `GAS_O2;
      conc_ff        <= `CONC_PURE;
      cmd_reject_out <= 1'b0;
    end else begin
      cmd_reject_out <= 1'b0;
      if (exec && rx_cnt_ff >= 3'h2) begin
        if (!meas_ff && rx_cnt_ff == 3'h2
            && (cmd_w == `CMD_START_O2 || cmd_w == `CMD_START_AIR)) begin
          // no argument with a pure gas
          meas_ff <= 1'b1;
          gas_ff  <= (cmd_w == `CMD_START_O2) ? `GAS_O2 : `GAS_AIR;
          conc_ff <= `CONC_PURE;
        end else if (!meas_ff && cmd_w == `CMD_START_MIX) begin
          if (arg_ok && arg_w <= `CONC_MAX) begin
            meas_ff <= 1'b1;
            gas_ff  <= `GAS_MIX;
            conc_ff <= arg_w[9:0];
          end else begin
            cmd_reject_out <= 1'b1;
          end
        end else if (meas_ff && cmd_w == `CMD_CONC_UPD) begin
          if (!arg_ok) cmd_reject_out <= 1'b1;
          else if (arg_w > `CONC_MAX) meas_ff <= 1'b0;
          else conc_ff <= arg_w[9:0];
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !meas_ff) begin
      warm_cnt_ff <= '0;
      warm_ff     <= 1'b0;
    end else if (!warm_ff) begin
      warm_cnt_ff <= warm_cnt_ff + 1'b1;
      warm_ff     <= (warm_cnt_ff == TW'(FIRST_CYC - 1));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !warm_ff) tick_cnt_ff <= '0;
    else if (tick) tick_cnt_ff <= '0;
    else tick_cnt_ff <= tick_cnt_ff + 1'b1;
  end
  assign tick = warm_ff && (tick_cnt_ff == TW'(SAMPLE_CYC - 1));

  // Drain stalls between ticks, so the FIFO fills and pushes back
  assign smp_take   = tick & smp_valid;
  assign fixed_mode = (avg_n_in != 8'h00);
  assign n_eff      = (avg_n_in > `AVG_N_MAX) ? {1'b0, `AVG_N_MAX} : {1'b0, avg_n_in};

  // averaging keeps refreshing results while running
  always_ff @(posedge mclk_in) begin
    logic signed [23:0] a;
    logic [8:0]         c;
    logic signed [19:0] d;
    a = '0;
    c = '0;
    d = '0;
    if (sys_rst_in || !meas_ff) begin
      acc_ff         <= '0;
      cnt_ff         <= '0;
      exp_ff         <= 1'b0;
      ema_ff         <= '0;
      data_ready_out <= 1'b0;
      res_ff         <= '0;
    end else begin
      a = (read_take && !fixed_mode) ? 24'sh000000 : acc_ff;
      c = (read_take && !fixed_mode) ? 9'h000 : cnt_ff;
      if (read_take && !fixed_mode) exp_ff <= 1'b0;
      if (smp_take) begin
        res_ff.temp    <= smp.temp;
        data_ready_out <= 1'b1;
        a = a + 24'(smp.flow);
        c = c + 9'h001;
        if (fixed_mode) begin
          if (c >= n_eff) begin
            res_ff.flow <= 16'(a / $signed({1'b0, c}));
            a = '0;
            c = '0;
          end
        end else if (exp_ff && !read_take) begin
          d = (20'(smp.flow) - 20'(ema_ff)) * `EXP_NUM;
          ema_ff      <= ema_ff + 16'(d >>> `EXP_SHIFT);
          res_ff.flow <= ema_ff + 16'(d >>> `EXP_SHIFT);
        end else begin
          res_ff.flow <= 16'(a / $signed({1'b0, c}));
          if (c == 9'(`AVG_LIMIT)) begin
            // 64 ms of means hand over to smoothing
            exp_ff <= 1'b1;
            ema_ff <= 16'(a / $signed({1'b0, c}));
          end
        end
      end
      acc_ff <= a;
      cnt_ff <= c;
    end
  end

  always_comb begin
    res_ff_status = {gas_ff, exp_ff & ~fixed_mode, fixed_mode, conc_ff};
  end

  // one snapshot serves the whole read transfer
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) shadow_ff <= '0;
    else if (read_take) shadow_ff <= '{res_ff.flow, res_ff.temp, res_ff_status};
  end

  // Visible state
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meas_active_out <= 1'b0;
      gas_sel_out     <= `GAS_O2;
    end else begin
      meas_active_out <= meas_ff;
      gas_sel_out     <= gas_ff;
    end
  end
endmodule

// ==== sim/flow_cmd_port_props.sv ====
// Checker on the ports of the flow sensor command port.
// Assumes SCL phases well above the pin synchroniser delay.
`timescale 1ns/10ps
module flow_cmd_port_props #(
  parameter int FIRST_CYC = 50
) (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_out,
  input  wire logic       sda_oe_out,
  input  wire logic       meas_active_out,
  input  wire logic       data_ready_out,
  input  wire logic [3:0] gas_sel_out,
  input  wire logic       cmd_reject_out
);
  int unsigned act_cyc_ff;

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Cycles since measurement began; saturates so it never wraps
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !meas_active_out) begin
      act_cyc_ff <= 0;
    end else if (act_cyc_ff != 32'hFFFF_FFFF) begin
      act_cyc_ff <= act_cyc_ff + 1;
    end
  end

  property p_open_drain;
    !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  property p_rst_idle;
    $fell(sys_rst_in) |-> !sda_oe_out && !meas_active_out && !data_ready_out;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("not idle after reset");
  // Data may only move while the bus clock is low
  property p_oe_scl_low;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data changed with clock high");
  property p_warmup;
    data_ready_out && meas_active_out |-> act_cyc_ff >= FIRST_CYC - 1;
  endproperty
  a_warmup: assert property (p_warmup)
    else $error("result before warm-up");
  property p_ready_holds;
    data_ready_out && meas_active_out ##1 meas_active_out |-> data_ready_out;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("results vanished while running");
  property p_gas_code;
    meas_active_out |-> gas_sel_out inside {4'h0, 4'h1, 4'h6};
  endproperty
  a_gas_code: assert property (p_gas_code)
    else $error("bad gas code");
  property p_gas_stable;
    meas_active_out && $past(meas_active_out) |-> $stable(gas_sel_out);
  endproperty
  a_gas_stable: assert property (p_gas_stable)
    else $error("gas changed while running");
  property p_reject;
    cmd_reject_out |=> !$rose(meas_active_out) && !cmd_reject_out;
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected start executed");

  c_ready: cover property ($rose(data_ready_out));
  c_reject: cover property (cmd_reject_out);
  c_mix: cover property (meas_active_out && gas_sel_out == 4'h6);
endmodule

bind flow_cmd_port flow_cmd_port_props #(.FIRST_CYC(FIRST_CYC)) flow_cmd_port_props_inst (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .meas_active_out(meas_active_out),
  .data_ready_out(data_ready_out), .gas_sel_out(gas_sel_out),
  .cmd_reject_out(cmd_reject_out));

// ==== sim/i2c_ctrl_model.sv ====
// Bus controller model: start, stop and nine-bit byte slots.
// Assumes a pulled-up data wire fed back on sda_in; clock idles high.
`timescale 1ns/10ps
module i2c_ctrl_model (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end

  task automatic hw(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic start();
    sda_drv_out = 1'b0;
    hw(8);
    scl_out = 1'b0;
    hw(4);
  endtask

  task automatic stop();
    sda_drv_out = 1'b0;
    hw(4);
    scl_out = 1'b1;
    hw(8);
    sda_drv_out = 1'b1;
    hw(8);
  endtask

  // MSB first
  // Data moves mid low phase so it never races the clock edge
  task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
    logic [8:0] sh;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_drv_out = sh[i];
      hw(4);
      scl_out = 1'b1;
      hw(8);
      sh[i] = sda_in;
      scl_out = 1'b0;
      hw(4);
    end
    rx = sh[8:1];
    ack_out = sh[0];
  endtask
endmodule

// ==== sim/flow_cmd_port_bench.sv ====
// Bench for the flow sensor command port, driving the bus via the controller model.
// Assumes short warm-up and sample periods set at the instance below.
`timescale 1ns/10ps
module flow_cmd_port_bench;
  logic        mclk_in, sys_rst_in, sample_valid, sample_ready, ack, scl, sda_drv;
  logic        sda_out, sda_oe, meas_active, data_ready, cmd_reject;
  logic [3:0]  gas_sel;
  logic [7:0]  avg_n;
  logic [7:0]  rb [0:8];
  logic [31:0] sample_data = {16'h1234, 16'hFF00};
  int          miscompares, n_compared, cyc, rejects, cnt;
  wire         sda = sda_drv & (sda_out | ~sda_oe);

  flow_cmd_port #(.SAMPLE_CYC(8), .FIRST_CYC(400)) flow_cmd_port_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .sample_valid_in(sample_valid),
    .sample_data_in(sample_data), .sample_ready_out(sample_ready), .avg_n_in(avg_n),
    .meas_active_out(meas_active), .data_ready_out(data_ready), .gas_sel_out(gas_sel),
    .cmd_reject_out(cmd_reject));
  i2c_ctrl_model i2c_ctrl_model_inst (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
    .sda_drv_out(sda_drv));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic rst();
    sys_rst_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
  endtask

  // Write nb bytes from the top of d; address answer lands in ack
  task automatic wr(input logic [6:0] a, input logic [39:0] d, input int nb);
    logic [7:0] rx;
    logic       k;
    i2c_ctrl_model_inst.start();
    i2c_ctrl_model_inst.xbyte({a, 1'b0}, 1'b1, rx, ack);
    for (int i = 0; i < nb && ack === 1'b0; i++) begin
      i2c_ctrl_model_inst.xbyte(d[39-8*i -: 8], 1'b1, rx, k);
    end
    i2c_ctrl_model_inst.stop();
  endtask

  // Read nb bytes, refusing the last one
  task automatic rd(input int nb);
    logic k;
    i2c_ctrl_model_inst.start();
    i2c_ctrl_model_inst.xbyte({7'h2A, 1'b1}, 1'b1, rb[0], ack);
    for (int i = 0; i < nb && ack === 1'b0; i++) begin
      i2c_ctrl_model_inst.xbyte(8'hFF, i == nb - 1, rb[i], k);
    end
    i2c_ctrl_model_inst.stop();
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction

  task automatic chk_set(input logic [15:0] st);
    logic [15:0] ex [0:2];
    ex = '{16'h1234, 16'hFF00, st};
    for (int k = 0; k < 3; k++) begin
      chk("word", ex[k], {rb[3*k], rb[3*k+1]});
      chk("crc", {8'h00, crc8(ex[k])}, {8'h00, rb[3*k+2]});
    end
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Reject pulses last one cycle, so count them; hang guard too
  always @(negedge mclk_in) begin
    cyc++;
    if (cmd_reject === 1'b1) rejects++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    sample_valid = 1'b0;
    avg_n = 8'h01;
    rst();
    rd(9);
    chk("idle header", 1, ack);
    wr(7'h2B, 40'h0, 0);
    chk("other address", 1, ack);
    $display("test addressing done");
    // Fill the FIFO while nothing drains it
    sample_valid = 1'b1;
    repeat (12) begin
      if (sample_ready === 1'b1) cnt++;
      @(negedge mclk_in);
    end
    sample_valid = 1'b0;
    chk("fifo taken", 8, cnt);
    wr(7'h2A, {16'h3608, 24'h0}, 2);
    chk("air mode", 16'h0011, {11'h0, meas_active, gas_sel});
    rd(9);
    chk("warm-up header", 1, ack);
    repeat (600) @(negedge mclk_in);
    chk("fifo drained", 1, sample_ready);
    sample_valid = 1'b1;
    rd(9);
    chk("data header", 0, ack);
    chk_set(16'h17FF);
    wr(7'h2A, {16'h3603, 24'h0}, 2);
    chk("restart ignored", 16'h0011, {11'h0, meas_active, gas_sel});
    rd(3);
    chk("abort flow", 16'h1234, {rb[0], rb[1]});
    chk("released", 0, sda_oe);
    rd(9);
    chk_set(16'h17FF);
    $display("test air done");
    for (int i = 0; i < 2; i++) begin
      rst();
      wr(7'h2A, {i ? 16'h3615 : 16'h3603, 24'h0}, 2);
      chk("code mode", i ? 16'h0000 : 16'h0010, {11'h0, meas_active, gas_sel});
    end
    $display("test codes done");
    rst();
    avg_n = 8'h00;
    wr(7'h2A, {16'h3632, 16'h01F4, crc8(16'h01F4) ^ 8'h01}, 5);
    chk("rejects", 1, rejects[15:0]);
    chk("bad arg mode", 0, {11'h0, meas_active, gas_sel});
    wr(7'h2A, {16'h3632, 16'h01F4, crc8(16'h01F4)}, 5);
    chk("mix mode", 16'h0016, {11'h0, meas_active, gas_sel});
    repeat (600) @(negedge mclk_in);
    rd(9);
    chk_set(16'h61F4);
    wr(7'h2A, {16'hE17D, 16'h0064, crc8(16'h0064)}, 5);
    rd(9);
    chk_set(16'h6864);
    $display("test mixture done");
    complete_run();
  end
endmodule
